// *** verilog/rph_port.sv ***
// phy side of the reduced interface data port with repeater straps
// How it works
// - capture transmit dibit each enabled reference tick, every tenth tick at the slow rate
// - transmit data ignored while enable low
// - carrier sense rises at once on carrier
// - carrier sense drops when carrier lost
// - carrier sense gapless, drops on tick after last
// - receive data 00 until decoding starts
// - one receive dibit per tick while valid, per ten ticks at the slow rate
// - receive data 00 while carrier sense low
// - symbol error flagged for a tick
// - back-to-back devices form fast repeater
// - straps 110 select nibble repeater mode
// - straps 101 select reduced repeater mode
// - continuous 50 MHz reference times port
`timescale 1ns/100ps
module rph_port
	import rph_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         resetn_in,
	input  wire logic         tx_en_in,
	input  wire logic [1:0]   txd_in,
	input  wire logic [2:0]   strap_in,
	input  wire logic         speed_100_in,
	input  wire rph_line_rx_t line_rx_in,
	input  wire rph_sense_t   sense_in,
	output logic              ref_clk_out,
	output logic              crs_dv_out,
	output logic [1:0]        rxd_out,
	output logic              rx_er_out,
	output rph_tx_t           tx_out,
	output rph_mode_t         mode_out
);

	// two non-adjacent zeros anywhere in the window
	function automatic logic gap_zeros(input logic [CARR_WIN-1:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < CARR_WIN - 2; i++) begin
			for (int j = i + 2; j < CARR_WIN; j++) begin
				if (!w[i] && !w[j])
					hit = 1'b1;
			end
		end
		return hit;
	endfunction

	function automatic rph_mode_t strap_mode(input logic [2:0] s);
		case (s)
			STRAP_MII_B2B:  return MODE_MII_B2B;
			STRAP_RMII_B2B: return MODE_RMII_B2B;
			default:        return MODE_NORMAL;
		endcase
	endfunction

	// pin synchronisers; no reset so straps are settled at release
	logic       tx_en_m_r, tx_en_s_r;
	logic [1:0] txd_m_r, txd_s_r;
	logic [2:0] strap_m_r, strap_s_r;
	logic       speed_m_r, speed_s_r;

	always_ff @(posedge clk_in) begin
		tx_en_m_r <= tx_en_in;
		tx_en_s_r <= tx_en_m_r;
		txd_m_r   <= txd_in;
		txd_s_r   <= txd_m_r;
		strap_m_r <= strap_in;
		strap_s_r <= strap_m_r;
		speed_m_r <= speed_100_in;
		speed_s_r <= speed_m_r;
	end

	wire tx_en_s = tx_en_s_r;

	// reference tick divider
	logic [2:0] div_cnt_r;
	logic       tick_r;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			div_cnt_r   <= 3'h0;
			tick_r      <= 1'b0;
			ref_clk_out <= 1'b0;
		end else begin
			div_cnt_r   <= (div_cnt_r == REF_DIV_M1) ? 3'h0 :
				div_cnt_r + 3'h1;
			tick_r      <= (div_cnt_r == REF_DIV_M1);
			ref_clk_out <= (div_cnt_r < REF_HIGH);
		end
	end

	// straps are caught on the first edge after reset release
	logic strap_done_r;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			strap_done_r <= 1'b0;
			mode_out     <= MODE_NORMAL;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			mode_out     <= strap_mode(strap_s_r);
		end
	end

	// repeater modes run only at the fast rate
	wire fast = speed_s_r || (mode_out != MODE_NORMAL);

	// carrier detection
	logic [CARR_WIN-1:0] win_r;
	logic                carrier_r;

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			win_r <= '1;
		else if (sense_in.bit_stb)
			win_r <= {win_r[CARR_WIN-2:0], sense_in.bit_val};
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			carrier_r <= 1'b0;
		else if (!sense_in.active)
			carrier_r <= 1'b0;
		else if (fast ? gap_zeros(win_r) : sense_in.squelch)
			carrier_r <= 1'b1;
	end

	// one decoded dibit waits here for its tick
	logic [1:0] pend_d_r;
	logic       pend_v_r;
	logic       err_pend_r;
	logic [3:0] rep_cnt_r;
	rph_rx_state_t rx_st_r;

	wire take = tick_r && (rep_cnt_r == 4'h0) && pend_v_r;
	wire last = tick_r && (rep_cnt_r == 4'h0) && !pend_v_r &&
		!carrier_r;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			pend_v_r <= 1'b0;
			pend_d_r <= DIBIT_IDLE;
		end else if (line_rx_in.vld) begin
			pend_v_r <= 1'b1;
			pend_d_r <= line_rx_in.dibit;
		end else if (take) begin
			pend_v_r <= 1'b0;
		end
	end

	// a new error beats the clear on the same tick
	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			err_pend_r <= 1'b0;
		else if (line_rx_in.err && carrier_r)
			err_pend_r <= 1'b1;
		else if (tick_r)
			err_pend_r <= 1'b0;
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			rep_cnt_r <= 4'h0;
		else if (take)
			rep_cnt_r <= fast ? 4'h0 : SLOW_HOLD_M1;
		else if (tick_r && rep_cnt_r != 4'h0)
			rep_cnt_r <= rep_cnt_r - 4'h1;
	end

	// rise any cycle, fall and data only on a tick
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rx_st_r    <= RX_IDLE;
			crs_dv_out <= 1'b0;
			rxd_out    <= DIBIT_IDLE;
		end else begin
			case (rx_st_r)
				RX_IDLE: begin
					if (carrier_r) begin
						rx_st_r    <= RX_WAIT;
						crs_dv_out <= 1'b1;
					end
				end
				RX_WAIT: begin
					if (take) begin
						rx_st_r <= RX_DATA;
						rxd_out <= pend_d_r;
					end else if (last) begin
						rx_st_r    <= RX_IDLE;
						crs_dv_out <= 1'b0;
					end
				end
				RX_DATA: begin
					if (take) begin
						rxd_out <= pend_d_r;
					end else if (last) begin
						rx_st_r    <= RX_IDLE;
						crs_dv_out <= 1'b0;
						rxd_out    <= DIBIT_IDLE;
					end
				end
				default: begin
					rx_st_r    <= RX_IDLE;
					crs_dv_out <= 1'b0;
					rxd_out    <= DIBIT_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			rx_er_out <= 1'b0;
		else if (tick_r)
			rx_er_out <= crs_dv_out && !last &&
				(err_pend_r || line_rx_in.err);
	end

	// transmit sampling; at the slow rate every tenth tick
	logic [3:0] tx_cnt_r;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			tx_cnt_r <= 4'h0;
			tx_out   <= '0;
		end else begin
			tx_out.vld <= 1'b0;
			if (tick_r) begin
				tx_out.frame <= tx_en_s;
				if (!tx_en_s) begin
					tx_cnt_r <= 4'h0;
				end else begin
					tx_cnt_r <= (fast || tx_cnt_r == SLOW_HOLD_M1) ?
						4'h0 : tx_cnt_r + 4'h1;
					if (tx_cnt_r == 4'h0) begin
						tx_out.vld   <= 1'b1;
						tx_out.dibit <= txd_s_r;
					end
				end
			end
		end
	end

	// checks
	a_tick_period: assert property (@(posedge clk_in) disable iff
		(!resetn_in) tick_r |=> !tick_r [*4] ##1 tick_r)
		else $error("reference tick period wrong");

	a_crs_fast_rise: assert property (@(posedge clk_in) disable iff
		(!resetn_in) $rose(carrier_r) && rx_st_r == RX_IDLE
		|=> crs_dv_out)
		else $error("carrier sense late");

	a_crs_fall_tick: assert property (@(posedge clk_in) disable iff
		(!resetn_in) $fell(crs_dv_out) |-> $past(tick_r)
		&& !$past(carrier_r))
		else $error("carrier sense fell off tick");

	a_rxd_wait_zero: assert property (@(posedge clk_in) disable iff
		(!resetn_in) rx_st_r == RX_WAIT |-> rxd_out == DIBIT_IDLE)
		else $error("data before decode");

	a_rxd_on_tick: assert property (@(posedge clk_in) disable iff
		(!resetn_in) !tick_r |=> $stable(rxd_out))
		else $error("receive data moved off tick");

	a_rxd_idle: assert property (@(posedge clk_in) disable iff
		(!resetn_in) !crs_dv_out |-> rxd_out == DIBIT_IDLE)
		else $error("receive data not idle");

	a_err_report: assert property (@(posedge clk_in) disable iff
		(!resetn_in) line_rx_in.err && carrier_r && crs_dv_out
		&& line_rx_in.vld |-> ##[1:6] rx_er_out)
		else $error("symbol error not flagged");

	a_rxer_on_tick: assert property (@(posedge clk_in) disable iff
		(!resetn_in) !tick_r |=> $stable(rx_er_out))
		else $error("receive error moved off tick");

	a_tx_capture: assert property (@(posedge clk_in) disable iff
		(!resetn_in) tick_r && tx_en_s && fast |=> tx_out.vld
		&& tx_out.dibit == $past(txd_s_r))
		else $error("transmit dibit missed");

	a_tx_ignore: assert property (@(posedge clk_in) disable iff
		(!resetn_in) tx_out.vld |-> $past(tx_en_s))
		else $error("idle transmit data taken");

	a_mode_strap: assert property (@(posedge clk_in) disable iff
		(!resetn_in) strap_done_r && !$past(strap_done_r)
		|-> mode_out == strap_mode($past(strap_s_r)))
		else $error("strap mode wrong");

	c_rx_frame: cover property (@(posedge clk_in) disable iff
		(!resetn_in) rx_st_r == RX_DATA ##[1:50] !crs_dv_out);
	c_rx_error: cover property (@(posedge clk_in) disable iff
		(!resetn_in) rx_er_out && crs_dv_out);
	c_tx_slow: cover property (@(posedge clk_in) disable iff
		(!resetn_in) tx_out.vld && !fast);
	c_b2b_mode: cover property (@(posedge clk_in) disable iff
		(!resetn_in) mode_out == MODE_RMII_B2B && crs_dv_out);

endmodule

// *** verilog/rph_pkg.sv ***
// constants and carrier types of the reduced-interface phy data port
package rph_pkg;

	// clock and reference timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int REF_PERIOD_NS = 20;
	localparam int REF_DIV = REF_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [2:0] REF_DIV_M1 = 3'(REF_DIV - 1);
	localparam logic [2:0] REF_HIGH = 3'(REF_DIV / 2);

	// dibit repeat count at the slow rate
	localparam int SLOW_HOLD = 10;
	localparam logic [3:0] SLOW_HOLD_M1 = 4'(SLOW_HOLD - 1);

	// carrier window at the fast rate
	localparam int CARR_WIN = 10;

	// idle value of the receive dibit bus
	localparam logic [1:0] DIBIT_IDLE = 2'h0;

	// strap codes
	localparam logic [2:0] STRAP_MII_B2B = 3'h6;
	localparam logic [2:0] STRAP_RMII_B2B = 3'h5;

	typedef enum logic [2:0] {
		MODE_NORMAL    = 3'b001,
		MODE_MII_B2B   = 3'b010,
		MODE_RMII_B2B  = 3'b100
	} rph_mode_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_WAIT = 3'b010,
		RX_DATA = 3'b100
	} rph_rx_state_t;

	// decoded receive stream from the line decoder
	typedef struct packed {
		logic [1:0] dibit;
		logic       vld;
		logic       err;
	} rph_line_rx_t;

	// raw carrier sensing from the line front end
	typedef struct packed {
		logic squelch;
		logic bit_val;
		logic bit_stb;
		logic active;
	} rph_sense_t;

	// transmit dibit handed to the line encoder
	typedef struct packed {
		logic [1:0] dibit;
		logic       vld;
		logic       frame;
	} rph_tx_t;

endpackage

// *** testbench/rph_mac_model.sv ***
// behavioural mac on the reduced interface, paced by the reference clock
`timescale 1ns/100ps
module rph_mac_model (
	input  wire logic  ref_in,
	input  wire logic  crs_dv_in,
	output logic       tx_en_out,
	output logic [1:0] txd_out,
	output logic       col_out
);
	// no collision pin on this port, so it is rebuilt here
	assign col_out = tx_en_out & crs_dv_in;
	// rx data and error are never read here: carrier sense alone matters
	initial begin
		tx_en_out = 1'b0;
		txd_out   = 2'h0;
	end
	// hold is reference periods per dibit: 1 fast, 10 slow
	task automatic send(input logic [1:0] d, input int hold);
		@(posedge ref_in);
		#1;
		tx_en_out = 1'b1;
		txd_out   = d;
		repeat (hold - 1) @(posedge ref_in);
	endtask
	// junk other than 00 only when a scenario asks for it
	task automatic stop(input logic [1:0] junk);
		@(posedge ref_in);
		#1;
		tx_en_out = 1'b0;
		txd_out   = junk;
	endtask
endmodule

// *** testbench/rph_port_bench.sv ***
// self-checking bench for the reduced-interface phy data port
`timescale 1ns/100ps
module rph_port_bench;
	import rph_pkg::*;
	logic         clk_in, resetn_in, tx_en_in, speed_100_in;
	logic         ref_clk_out, crs_dv_out, rx_er_out;
	logic         started = 1'b0;
	time          t0;
	logic [1:0]   txd_in, rxd_out;
	logic [2:0]   strap_in;
	rph_line_rx_t line_rx_in;
	rph_sense_t   sense_in;
	rph_tx_t      tx_out;
	rph_mode_t    mode_out;
	logic [31:0]  seed = 32'h0001_69ee;
	logic [1:0]   txq[$];
	logic [2:0]   rxq[$];
	int           failures, checked;
	rph_mode_t    md[3] = '{MODE_MII_B2B, MODE_RMII_B2B, MODE_NORMAL};
	logic [2:0]   st[3] = '{STRAP_MII_B2B, STRAP_RMII_B2B, 3'h1};

	rph_port uut (.clk_in(clk_in), .resetn_in(resetn_in),
		.tx_en_in(tx_en_in), .txd_in(txd_in), .strap_in(strap_in),
		.speed_100_in(speed_100_in), .line_rx_in(line_rx_in),
		.sense_in(sense_in), .ref_clk_out(ref_clk_out),
		.crs_dv_out(crs_dv_out), .rxd_out(rxd_out), .rx_er_out(rx_er_out),
		.tx_out(tx_out), .mode_out(mode_out));
	rph_mac_model mac (.ref_in(ref_clk_out), .crs_dv_in(crs_dv_out),
		.tx_en_out(tx_en_in), .txd_out(txd_in), .col_out());

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	function logic [1:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[1:0];
	endfunction

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wait_crs(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && crs_dv_out !== v; i++) begin
			@(posedge clk_in);
			#1;
		end
		check({3'h0, crs_dv_out}, {3'h0, v});
		if (crs_dv_out !== v) conclude();
	endtask

	task automatic tx_frame(input int n, input int hold);
		logic [1:0] d;
		repeat (n) begin
			d = rnd();
			txq.push_back(d);
			mac.send(d, hold);
		end
		mac.stop(rnd() | 2'h1);
		repeat (30) @(posedge clk_in);
		mac.stop(2'h0);
	endtask

	// called just after a reference edge; the dibit shows from the next
	// reference edge on and stands hold periods, the error only the first
	task automatic rx_send(input logic [1:0] d, input logic e,
		input int hold);
		line_rx_in = '{dibit: d, vld: 1'b1, err: e};
		@(posedge clk_in);
		#1;
		line_rx_in = '0;
		@(posedge ref_clk_out);
		#1;
		rxq.push_back({e, d});
		repeat (hold - 1) rxq.push_back({1'b0, d});
		repeat (hold - 1) begin
			@(posedge ref_clk_out);
			#1;
		end
	endtask

	always begin
		@(posedge clk_in);
		#1;
		if (tx_out.vld === 1'b1) begin
			if (txq.size() == 0) check(4'h1, 4'h0);
			else check(tx_out, {txq.pop_front(), 2'h3});
		end
	end

	always begin
		@(negedge ref_clk_out);
		#1;
		if (crs_dv_out !== 1'b1) begin
			started = 1'b0;
			check({1'b0, rx_er_out, rxd_out}, 4'h0);
		end else if (rxq.size() > 0) begin
			started = 1'b1;
			check({1'b0, rx_er_out, rxd_out}, {1'b0, rxq.pop_front()});
		end else if (!started) check({1'b0, rx_er_out, rxd_out}, 4'h0);
	end

	initial begin
		#200000;
		failures++;
		conclude();
	end

	initial begin
		resetn_in = 1'b0;
		speed_100_in = 1'b1;
		strap_in = 3'h1;
		line_rx_in = '0;
		sense_in = '0;
		// back-to-back modes must run fast although the speed pin says slow
		for (int i = 0; i < 3; i++) begin
			strap_in = st[i];
			resetn_in = 1'b0;
			repeat (12) @(posedge clk_in);
			#1;
			resetn_in = 1'b1;
			repeat (2) @(posedge clk_in);
			#1;
			check({1'b0, mode_out}, {1'b0, md[i]});
			@(posedge ref_clk_out);
			t0 = $time;
			@(posedge ref_clk_out);
			check(4'(($time - t0) / CLK_PERIOD_NS), 4'(REF_DIV));
			speed_100_in = (i == 2);
			tx_frame(5, 1);
		end
		sense_in.active = 1'b1;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_in);
			#1;
			sense_in.bit_val = k[0];
			sense_in.bit_stb = 1'b1;
		end
		@(posedge clk_in);
		#1;
		sense_in.bit_stb = 1'b0;
		wait_crs(1'b1, 4);
		@(posedge ref_clk_out);
		#1;
		for (int k = 0; k < 8; k++) rx_send(rnd(), k == 3, 1);
		sense_in.active = 1'b0;
		wait_crs(1'b0, 12);
		speed_100_in = 1'b0;
		tx_frame(3, 10);
		sense_in = '{1'b1, 1'b0, 1'b0, 1'b1};
		wait_crs(1'b1, 4);
		@(posedge ref_clk_out);
		#1;
		for (int k = 0; k < 2; k++) rx_send(rnd(), 1'b0, 10);
		sense_in = '0;
		wait_crs(1'b0, 60);
		repeat (20) @(posedge clk_in);
		check(4'(txq.size() + rxq.size()), 4'h0);
		conclude();
	end
endmodule
